// File: hw/soft_reset_map.svh
// Purpose: offsets, field positions, reset values for the soft reset bank
// Assumes: 32-bit apb data, byte addresses
// Notes:   capability words are plain inputs to the block
// Functional notes
// - the second reset control word sits at 0x048, 32 bits, reset to all zeros.
// - writes to the second word are masked by capability word four.
// - bit 30 of the second word drives the ethernet phy reset.
// - bit 28 of the second word drives the ethernet mac reset.
// - bits 6..0 of the second word drive the resets of ports g down to a.
// - bit 8 of the first word drives the quadrature encoder reset.
// - bit 4 of the first word drives the synchronous serial reset.
// - bits 2, 1 and 0 of the first word drive async serial units 2, 1, 0.
// - reserved bits of both words read zero and ignore writes.
// - the first word sits at 0x044 and its writes are masked by capability word two.
`ifndef SOFT_RESET_MAP_SVH
`define SOFT_RESET_MAP_SVH
`define SRC_ONE_OFFSET   12'h044
`define SRC_TWO_OFFSET   12'h048
`define SRC_RESET_VALUE  32'h0000_0000
`define SRC_ONE_IMPL     32'h0000_0117
`define SRC_TWO_IMPL     32'h5000_007F
`define SRC_PHY_BIT      30
`define SRC_MAC_BIT      28
`define SRC_QEI_BIT      8
`define SRC_SSI_BIT      4
`define SRC_PORT_LSB     0
`define SRC_PORT_COUNT   7
`define SRC_ASYNC_LSB    0
`define SRC_ASYNC_COUNT  3
`endif

// File: hw/soft_reset_pkg.sv
// Purpose: types for the soft reset bank
// Assumes: nothing
// Notes:   apb request carrier
package soft_reset_pkg;
	typedef struct packed {
		logic        sel;
		logic        enable;
		logic        write;
		logic [11:0] addr;
		logic [31:0] wdata;
	} apb_req_t;

	typedef enum logic [1:0] {
		SEL_NONE,
		SEL_ONE,
		SEL_TWO
	} reg_sel_t;
endpackage

// File: hw/masked_reset_word.sv
// Purpose: one masked read-write reset control word
// Assumes: write strobe is one cycle, same clock
// Notes:   reserved bits hold zero forever
`timescale 1ns/1ns
`include "soft_reset_map.svh"
module masked_reset_word #(
	parameter logic [31:0] IMPL_MASK = 32'h0000_0000
) (
	input  wire logic        pclk,
	input  wire logic        presetn,
	input  wire logic        wr_en,
	input  wire logic [31:0] wr_data,
	input  wire logic [31:0] cap_mask,
	output logic      [31:0] value
);
	logic [31:0] value_q;
	logic [31:0] value_d;
	logic [31:0] keep;

	// next value: only implemented and capable bits may change
	always_comb begin
		keep    = IMPL_MASK & cap_mask;
		value_d = value_q & IMPL_MASK;
		if (wr_en) begin
			value_d = (value_q & ~keep & IMPL_MASK) | (wr_data & keep);
		end
	end

	// state register
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			value_q <= `SRC_RESET_VALUE;
		end else begin
			value_q <= value_d;
		end
	end

	assign value = value_q;
endmodule

// File: hw/peripheral_soft_reset_control.sv
// Purpose: apb soft reset bank driving per-peripheral reset requests
// Assumes: capability words static, on pclk domain
// Notes:   zero wait state slave, errors never flagged
`timescale 1ns/1ns
`include "soft_reset_map.svh"
module peripheral_soft_reset_control (
	input  wire logic        pclk,
	input  wire logic        presetn,
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [11:0] paddr,
	input  wire logic [31:0] pwdata,
	input  wire logic [31:0] capability_word_two,
	input  wire logic [31:0] capability_word_four,
	output logic      [31:0] prdata,
	output logic             pready,
	output logic             pslverr,
	output logic             eth_phy_reset,
	output logic             eth_mac_reset,
	output logic      [6:0]  port_reset,
	output logic             quad_encoder_reset,
	output logic             sync_serial_reset,
	output logic      [2:0]  async_serial_reset
);
	soft_reset_pkg::apb_req_t req;
	soft_reset_pkg::reg_sel_t sel;
	logic [31:0] soft_reset_control_one;
	logic [31:0] soft_reset_control_two;
	logic        wr_one;
	logic        wr_two;
	logic [31:0] prdata_d;
	logic [31:0] prdata_q;
	logic [31:0] one_d;
	logic [31:0] two_d;
	logic [31:0] one_q;
	logic [31:0] two_q;
	logic        pready_d;
	logic        pready_q;
	logic        pslverr_d;
	logic        pslverr_q;

	// ************************************************
	// apb decode
	// ************************************************

	// gather request and decode address
	always_comb begin
		req = '{sel: psel, enable: penable, write: pwrite, addr: paddr, wdata: pwdata};
		sel = soft_reset_pkg::SEL_NONE;
		if (req.addr == `SRC_ONE_OFFSET) begin
			sel = soft_reset_pkg::SEL_ONE;
		end else if (req.addr == `SRC_TWO_OFFSET) begin
			sel = soft_reset_pkg::SEL_TWO;
		end
	end

	// write strobes on the access phase
	assign wr_one = req.sel && req.enable && req.write && (sel == soft_reset_pkg::SEL_ONE);
	assign wr_two = req.sel && req.enable && req.write && (sel == soft_reset_pkg::SEL_TWO);

	// ************************************************
	// control words
	// ************************************************

	// first word, masked by capability word two
	masked_reset_word #(
		.IMPL_MASK (`SRC_ONE_IMPL)
	) u_word_one (
		.pclk     (pclk),
		.presetn  (presetn),
		.wr_en    (wr_one),
		.wr_data  (req.wdata),
		.cap_mask (capability_word_two),
		.value    (soft_reset_control_one)
	);

	// second word, masked by capability word four
	masked_reset_word #(
		.IMPL_MASK (`SRC_TWO_IMPL)
	) u_word_two (
		.pclk     (pclk),
		.presetn  (presetn),
		.wr_en    (wr_two),
		.wr_data  (req.wdata),
		.cap_mask (capability_word_four),
		.value    (soft_reset_control_two)
	);

	// ************************************************
	// read path
	// ************************************************

	// read data, unmapped reads zero; reserved already zero
	always_comb begin
		prdata_d = 32'h0000_0000;
		if (req.sel && !req.enable && !req.write) begin
			unique case (sel)
				soft_reset_pkg::SEL_ONE: prdata_d = soft_reset_control_one;
				soft_reset_pkg::SEL_TWO: prdata_d = soft_reset_control_two;
				soft_reset_pkg::SEL_NONE: prdata_d = 32'h0000_0000;
			endcase
		end else if (req.sel && req.enable) begin
			prdata_d = prdata_q;
		end
	end

	// registered read data
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prdata_q <= 32'h0000_0000;
		end else begin
			prdata_q <= prdata_d;
		end
	end

	assign prdata  = prdata_q;

	// ************************************************
	// bus answer
	// ************************************************

	// answer flags: zero wait, never an error
	always_comb begin
		pready_d  = 1'b1;
		pslverr_d = 1'b0;
	end

	// answer flops, so every bus output leaves a register
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pready_q  <= 1'b1;
			pslverr_q <= 1'b0;
		end else begin
			pready_q  <= pready_d;
			pslverr_q <= pslverr_d;
		end
	end

	assign pready  = pready_q;
	assign pslverr = pslverr_q;

	// ************************************************
	// reset request outputs
	// ************************************************

	// output copies of the words, registered
	always_comb begin
		one_d = soft_reset_control_one;
		two_d = soft_reset_control_two;
	end

	// output flops: a one holds the peripheral in reset
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			one_q <= `SRC_RESET_VALUE;
			two_q <= `SRC_RESET_VALUE;
		end else begin
			one_q <= one_d;
			two_q <= two_d;
		end
	end

	assign eth_phy_reset      = two_q[`SRC_PHY_BIT];
	assign eth_mac_reset      = two_q[`SRC_MAC_BIT];
	assign quad_encoder_reset = one_q[`SRC_QEI_BIT];
	assign sync_serial_reset  = one_q[`SRC_SSI_BIT];

	// per-port and per-unit fan out
	genvar i;
	generate
		for (i = 0; i < `SRC_PORT_COUNT; i++) begin : g_port
			assign port_reset[i] = two_q[`SRC_PORT_LSB + i];
		end
		for (i = 0; i < `SRC_ASYNC_COUNT; i++) begin : g_async
			assign async_serial_reset[i] = one_q[`SRC_ASYNC_LSB + i];
		end
	endgenerate
endmodule

// File: dv/peripheral_soft_reset_control_asserts.sv
// Purpose: port checks for the soft reset bank
// Assumes: zero wait apb, capability words static
// Notes:   reset lines trail the stored word by a cycle
`timescale 1ns/1ns
module peripheral_soft_reset_control_asserts (
	input wire logic        pclk, presetn, psel, penable, pwrite, pready, pslverr,
	input wire logic        eth_phy_reset, eth_mac_reset, quad_encoder_reset, sync_serial_reset,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata, prdata, capability_word_two, capability_word_four,
	input wire logic [6:0]  port_reset,
	input wire logic [2:0]  async_serial_reset
);
	// decoded transfers and words rebuilt from the reset lines
	wire logic [31:0] c2 = capability_word_two, c4 = capability_word_four;
	wire logic w1 = psel && penable && pwrite && paddr == 12'h044;
	wire logic w2 = psel && penable && pwrite && paddr == 12'h048;
	wire logic rd = psel && penable && !pwrite;
	wire logic [31:0] o1 = {23'h0, quad_encoder_reset, 3'h0, sync_serial_reset, 1'b0, async_serial_reset};
	wire logic [31:0] o2 = {1'b0, eth_phy_reset, 1'b0, eth_mac_reset, 21'h0, port_reset};
	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);
	// bus answer and reset line behaviour
	rdy_ok_a: assert property (psel && penable |-> pready && !pslverr) else $error("answer");
	idle_hold_a: assert property (!(w1 || w2) |-> ##2 $stable({o1, o2})) else $error("drift");
	phy_set_a: assert property (w2 && c4[30] |-> ##2 eth_phy_reset == $past(pwdata[30], 2)) else $error("phy");
	mac_keep_a: assert property (w2 && !c4[28] |-> ##2 $stable(eth_mac_reset)) else $error("mac");
	port_mix_a: assert property (w2 |-> ##2 port_reset == ($past(pwdata[6:0], 2) & c4[6:0] |
		$past(port_reset) & ~c4[6:0])) else $error("port");
	async_mix_a: assert property (w1 |-> ##2 async_serial_reset == ($past(pwdata[2:0], 2) & c2[2:0] |
		$past(async_serial_reset) & ~c2[2:0])) else $error("async");
	rd_two_a: assert property (rd && paddr == 12'h048 |-> prdata == o2) else $error("rd2");
	rd_one_a: assert property (rd && paddr == 12'h044 |-> prdata == o1) else $error("rd1");
	cover property (w2 && c4[30]);
	cover property (w1 && !c2[0]);
	cover property (rd && paddr == 12'h050);
endmodule

// File: dv/periph_bank_model.sv
// Purpose: peripherals taking the reset lines
// Assumes: level requests on pclk
// Notes:   running returns a cycle after release
`timescale 1ns/1ns
module periph_bank_model (
	input  wire logic        pclk,
	input  wire logic [13:0] hold,
	output logic      [13:0] running
);
	// each unit idles while its request is high
	always_ff @(posedge pclk) begin
		running <= ~hold;
	end
endmodule

// File: dv/peripheral_soft_reset_control_test.sv
// Purpose: random apb regression of the soft reset bank
// Assumes: zero wait slave
// Notes:   words modelled from masked writes
`timescale 1ns/1ns
module peripheral_soft_reset_control_test;
	logic        pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, pready, pslverr;
	logic        eth_phy_reset, eth_mac_reset, quad_encoder_reset, sync_serial_reset;
	logic [11:0] paddr = 12'h000, a;
	logic [31:0] pwdata = 32'h0, capability_word_two = 32'h0, capability_word_four = 32'h0;
	logic [31:0] prdata, rd, d, m1, m2;
	logic [6:0]  port_reset;
	logic [2:0]  async_serial_reset;
	logic [13:0] running;
	int          err_total = 0, compares = 0, seed = 7;
	always #50 pclk = ~pclk;
	peripheral_soft_reset_control i_dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
		.capability_word_two, .capability_word_four, .pready, .pslverr, .eth_phy_reset, .eth_mac_reset,
		.port_reset, .quad_encoder_reset, .sync_serial_reset, .async_serial_reset);
	periph_bank_model i_bank (.pclk, .running, .hold({eth_phy_reset, eth_mac_reset, port_reset,
		quad_encoder_reset, sync_serial_reset, async_serial_reset}));
	// compare, masked merge, bus cycle, verdict
	task automatic chk(input string what, input logic [31:0] exp, got);
		compares++;
		if (got !== exp) begin
			err_total++;
			$display("wrong value %s expected %h seen %h", what, exp, got);
		end
	endtask
	function automatic logic [31:0] mrg(input logic [31:0] o, n, k);
		return o & ~k | n & k;
	endfunction
	task automatic apb(input logic [11:0] ad, input logic w, input logic [31:0] wd);
		psel <= 1'b1;
		paddr <= ad;
		pwrite <= w;
		pwdata <= wd;
		@(posedge pclk);
		penable <= 1'b1;
		do @(posedge pclk); while (pready !== 1'b1);
		rd = prdata;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge pclk);
	endtask
	task automatic results;
		if (err_total == 0 && compares > 0) begin
			$display("Regression OK");
		end else begin
			$display("Regression broken");
		end
		$finish;
	endtask
	// random writes to both words and two unmapped places
	initial begin
		m1 = 0;
		m2 = 0;
		repeat (12) @(posedge pclk);
		presetn <= 1'b1;
		apb(12'h048, 1'b0, 32'h0);
		chk("word two", 32'h0, rd);
		for (int i = 0; i < 64; i++) begin
			capability_word_two <= i % 8 == 0 ? 32'hFFFF_FFFF : i % 8 == 1 ? 32'h0 : $random(seed);
			capability_word_four <= i % 8 == 0 ? 32'hFFFF_FFFF : i % 8 == 1 ? 32'h0 : $random(seed);
			a = 12'h044 + 12'(4 * ($random(seed) & 3));
			d = i % 8 == 2 ? 32'hFFFF_FFFF : $random(seed);
			apb(a, 1'b1, d);
			if (a == 12'h044) m1 = mrg(m1, d, capability_word_two & 32'h0000_0117);
			if (a == 12'h048) m2 = mrg(m2, d, capability_word_four & 32'h5000_007F);
			apb(12'h044, 1'b0, d);
			chk("word one", m1, rd);
			apb(12'h048, 1'b0, d);
			chk("word two", m2, rd);
			apb(12'h050, 1'b0, d);
			chk("unmapped", 32'h0, rd);
			chk("running", {18'h0, ~{m2[30], m2[28], m2[6:0], m1[8], m1[4], m1[2:0]}}, {18'h0, running});
		end
		// fill both words, then reset mid-run
		capability_word_two <= 32'hFFFF_FFFF;
		capability_word_four <= 32'hFFFF_FFFF;
		apb(12'h048, 1'b1, 32'hFFFF_FFFF);
		apb(12'h044, 1'b1, 32'hFFFF_FFFF);
		presetn <= 1'b0;
		repeat (3) @(posedge pclk);
		presetn <= 1'b1;
		m1 = 0;
		m2 = 0;
		apb(12'h048, 1'b0, 32'h0);
		chk("word two", 32'h0000_0000, rd);
		apb(12'h044, 1'b0, 32'h0);
		chk("word one", 32'h0000_0000, rd);
		chk("running", 32'h0000_3FFF, {18'h0, running});
		results;
	end
	// hang guard
	initial begin
		#256000;
		err_total++;
		results;
	end
endmodule
bind peripheral_soft_reset_control peripheral_soft_reset_control_asserts i_chk (.*);
